/* hdl/pmt_params.svh */
`ifndef PMT_PARAMS_SVH
`define PMT_PARAMS_SVH

`define PMT_ENTRIES        65536
`define PMT_IDX_W          16
`define PMT_BASE_LO        20'h00200
`define PMT_BASE_HI        20'h401FC
`define PMT_VALID_BIT      31
`define PMT_SPARE_BIT      30
`define PMT_PFN_MSB        29
`define PMT_ENTRY_RESET    32'h00000000
`define PMT_OFS_512        9
`define PMT_OFS_4K         12
`define PMT_OFS_8K         13
`define PMT_SYS_W          40
`define PMT_VME_W          32
`define PMT_ADDR_W         20

`endif

/* hdl/pmt_pkg.sv */
package pmt_pkg;
  typedef enum logic [1:0] {
    PMT_MODE_34_512,
    PMT_MODE_40_512,
    PMT_MODE_40_4K,
    PMT_MODE_40_8K
  } pmt_mode_t;
endpackage

/* hdl/pmt_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pmt_mem_if #(parameter int IDX_W = 16);
  logic             we;
  logic [IDX_W-1:0] waddr;
  logic [31:0]      wdata;
  logic [IDX_W-1:0] raddr;
  logic [31:0]      rdata;
  logic             clr;
  modport ctl (output we, output waddr, output wdata, output raddr, output clr,
               input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, input clr,
               output rdata);
endinterface
`default_nettype wire

/* hdl/pmt_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmt_params.svh"
module pmt_mem #(
  parameter int IDX_W = `PMT_IDX_W
) (
  input  wire logic i_core_clk,
  pmt_mem_if.mem    bus
);
  import pmt_pkg::*;
  logic [31:0] ram [0:(1<<IDX_W)-1];
  logic [31:0] rdata_q;
  // per-entry valid kept in flops so reset can clear every entry at once
  logic [(1<<IDX_W)-1:0] live;
  assign bus.rdata = rdata_q;
  always_ff @(posedge i_core_clk) begin
    if (bus.we)
      ram[bus.waddr] <= bus.wdata;
    rdata_q <= live[bus.raddr] ? ram[bus.raddr] : `PMT_ENTRY_RESET;
  end
  always_ff @(posedge i_core_clk) begin
    if (bus.clr)
      live <= '0;
    else if (bus.we)
      live[bus.waddr] <= 1'b1;
  end
endmodule
`default_nettype wire

/* hdl/pmt_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmt_params.svh"
module pmt_top #(
  parameter int IDX_W = `PMT_IDX_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [19:0]       i_reg_addr,
  input  wire logic [31:0]       i_reg_wdata,
  output var  logic [31:0]       o_reg_rdata,
  output var  logic              o_reg_rvalid,
  input  wire logic              i_dma_req,
  input  wire pmt_pkg::pmt_mode_t i_mode,
  input  wire logic [31:0]       i_vme_addr,
  input  wire logic [5:0]        i_vme_cmd,
  output var  logic              o_dma_done,
  output var  logic              o_dma_abort,
  output var  logic [39:0]       o_sys_addr,
  output var  logic              o_err_invalid_frame,
  output var  logic [31:0]       o_err_vme_addr,
  output var  logic [5:0]        o_err_vme_cmd,
  input  wire logic              i_err_clear
);
  import pmt_pkg::*;

  pmt_mem_if #(.IDX_W(IDX_W)) mif ();
  pmt_mem #(.IDX_W(IDX_W)) u_mem (
    .i_core_clk (i_core_clk),
    .bus        (mif.mem)
  );

  function automatic logic [IDX_W-1:0] page_index(input pmt_mode_t m,
                                                  input logic [31:0] a);
    case (m)
      PMT_MODE_40_4K: page_index = a[`PMT_OFS_4K +: IDX_W];
      PMT_MODE_40_8K: page_index = a[`PMT_OFS_8K +: IDX_W];
      default:        page_index = a[`PMT_OFS_512 +: IDX_W];
    endcase
  endfunction

  typedef enum logic [1:0] {PMT_IDLE, PMT_LOOK, PMT_XLATE} pmt_state_t;
  pmt_state_t state;
  pmt_state_t next_state;
  logic       rd_pend;
  pmt_mode_t  mode_q;
  logic [31:0] vaddr_q;
  logic [5:0]  vcmd_q;
  logic        rd_hit_q;

  wire        in_range = (i_reg_addr >= `PMT_BASE_LO) && (i_reg_addr <= `PMT_BASE_HI)
                         && (i_reg_addr[1:0] == 2'h0);
  wire [19:0] rel      = i_reg_addr - `PMT_BASE_LO;
  wire [IDX_W-1:0] reg_idx = rel[IDX_W+1:2];
  wire        reg_wr_hit = i_reg_wr && in_range;
  wire        reg_rd_hit = i_reg_rd && in_range;
  // register reads own the memory port; dma lookup waits a cycle
  wire        dma_go   = (state == PMT_IDLE) && i_dma_req && !reg_rd_hit;

  // index of a fresh request, and of the one held while the lookup runs
  wire [IDX_W-1:0] req_idx  = page_index(i_mode, i_vme_addr);
  wire [IDX_W-1:0] held_idx = page_index(mode_q, vaddr_q);
  // the requester may drop its address after the take edge, so the
  // second read of the lookup must come from the held copy
  // a register read that lands in the lookup cycle steals the port;
  // the lookup repeats one cycle instead of using foreign data
  wire        look_blocked = (state == PMT_LOOK) && reg_rd_hit;

  wire [31:0] ent       = mif.rdata;
  wire        ent_valid = ent[`PMT_VALID_BIT];
  wire [29:0] page_frame_number       = ent[`PMT_PFN_MSB:0];

  logic [39:0] xl_addr;
  always_comb begin
    case (mode_q)
      PMT_MODE_34_512: xl_addr = {6'h00, page_frame_number[24:0], vaddr_q[8:0]};
      PMT_MODE_40_512: xl_addr = {1'b0, page_frame_number[29:0], vaddr_q[8:0]};
      PMT_MODE_40_4K:  xl_addr = {1'b0, page_frame_number[26:0], vaddr_q[11:0]};
      PMT_MODE_40_8K:  xl_addr = {1'b0, page_frame_number[25:0], vaddr_q[12:0]};
      default:         xl_addr = 40'h00_0000_0000;
    endcase
  end

  assign mif.we    = reg_wr_hit;
  assign mif.waddr = reg_idx;
  assign mif.wdata = i_reg_wdata;
  assign mif.clr   = i_srst;
  assign mif.raddr = reg_rd_hit ? reg_idx :
                     (state == PMT_IDLE) ? req_idx : held_idx;

  always_comb begin
    case (state)
      PMT_IDLE:  next_state = dma_go ? PMT_LOOK : PMT_IDLE;
      PMT_LOOK:  next_state = look_blocked ? PMT_LOOK : PMT_XLATE;
      PMT_XLATE: next_state = PMT_IDLE;
      default:   next_state = PMT_IDLE;
    endcase
  end

  wire bad_frame = (state == PMT_XLATE) && !ent_valid;
  wire good_xl   = (state == PMT_XLATE) && ent_valid;

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state   <= PMT_IDLE;
      mode_q  <= PMT_MODE_34_512;
      vaddr_q <= 32'h0000_0000;
      vcmd_q  <= 6'h00;
    end else begin
      state <= next_state;
      if (dma_go) begin
        mode_q  <= i_mode;
        vaddr_q <= i_vme_addr;
        vcmd_q  <= i_vme_cmd;
      end
    end
  end

  // read data valid two cycles after strobe: address phase, then ram register
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      rd_pend      <= 1'b0;
      o_reg_rvalid <= 1'b0;
      o_reg_rdata  <= 32'h0000_0000;
    end else begin
      rd_pend      <= i_reg_rd;
      o_reg_rvalid <= rd_pend;
      // unmapped reads return zero
      o_reg_rdata  <= rd_pend ? (rd_hit_q ? ent : 32'h0000_0000) : 32'h0000_0000;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (i_srst)
      rd_hit_q <= 1'b0;
    else
      rd_hit_q <= reg_rd_hit;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_dma_done  <= 1'b0;
      o_dma_abort <= 1'b0;
      o_sys_addr  <= 40'h00_0000_0000;
    end else begin
      o_dma_done  <= good_xl;
      o_dma_abort <= bad_frame;
      if (good_xl)
        o_sys_addr <= xl_addr;
    end
  end

  // capture only on first error; new error in the clearing cycle still sets
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_err_invalid_frame <= 1'b0;
      o_err_vme_addr      <= 32'h0000_0000;
      o_err_vme_cmd       <= 6'h00;
    end else begin
      if (bad_frame && (!o_err_invalid_frame || i_err_clear)) begin
        o_err_vme_addr <= vaddr_q;
        o_err_vme_cmd  <= vcmd_q;
      end
      o_err_invalid_frame <= bad_frame || (o_err_invalid_frame && !i_err_clear);
    end
  end
endmodule
`default_nettype wire

/* bench/pmt_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module pmt_top_assertions (
  input wire logic               i_core_clk,
  input wire logic               i_srst,
  input wire logic               i_reg_rd,
  input wire logic               o_reg_rvalid,
  input wire pmt_pkg::pmt_mode_t i_mode,
  input wire logic [31:0]        i_vme_addr,
  input wire logic               o_dma_done,
  input wire logic               o_dma_abort,
  input wire logic [39:0]        o_sys_addr,
  input wire logic               o_err_invalid_frame,
  input wire logic [31:0]        o_err_vme_addr,
  input wire logic               i_err_clear
);
  import pmt_pkg::*;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  sequence s_rd_answer;
    ##2 o_reg_rvalid;
  endsequence
  // om: offset bits copied from the request, zm: bits forced low
  property p_xl(pmt_mode_t m, logic [39:0] om, logic [39:0] zm);
    o_dma_done && $past(i_mode, 3) == m |->
      ((o_sys_addr ^ {8'h00, $past(i_vme_addr, 3)}) & om) == 40'h0 && (o_sys_addr & zm) == 40'h0;
  endproperty
  AST_RD_ANSWER: assert property (i_reg_rd |-> s_rd_answer)
    else $error("read not answered");
  AST_X34: assert property (p_xl(PMT_MODE_34_512, 40'h1FF, 40'hFC00000000))
    else $error("narrow 512 address wrong");
  AST_W512: assert property (p_xl(PMT_MODE_40_512, 40'h1FF, 40'h8000000000))
    else $error("wide 512 address wrong");
  AST_W4K: assert property (p_xl(PMT_MODE_40_4K, 40'hFFF, 40'h8000000000))
    else $error("wide 4K address wrong");
  AST_W8K: assert property (p_xl(PMT_MODE_40_8K, 40'h1FFF, 40'h8000000000))
    else $error("wide 8K address wrong");
  AST_ONE_OUTCOME: assert property (!(o_dma_done && o_dma_abort))
    else $error("done and abort together");
  AST_ERR_CAPTURE: assert property (o_dma_abort && !$past(o_err_invalid_frame) |->
    o_err_invalid_frame && o_err_vme_addr == $past(i_vme_addr, 3))
    else $error("first error not captured");
  AST_ERR_HOLD: assert property (o_err_invalid_frame && !i_err_clear |=>
    o_err_invalid_frame && $stable(o_err_vme_addr))
    else $error("error capture not held");
endmodule
bind pmt_top pmt_top_assertions pmt_top_assertions_inst (.*);
`default_nettype wire

/* bench/pmt_dma_master.sv */
`timescale 1ns/1ps
`default_nettype none
module pmt_dma_master (
  input  wire logic               i_core_clk,
  input  wire logic               i_done,
  input  wire logic               i_abort,
  output var  logic               o_req,
  output var  pmt_pkg::pmt_mode_t o_mode,
  output var  logic [31:0]        o_addr,
  output var  logic [5:0]         o_cmd
);
  import pmt_pkg::*;
  initial begin
    {o_req, o_addr, o_cmd} = '0;
    o_mode = PMT_MODE_34_512;
  end
  task automatic xfer(input pmt_mode_t m, input logic [31:0] a, input int gap, output logic ok);
    int n;
    repeat (gap) @(negedge i_core_clk);
    @(negedge i_core_clk);
    {o_req, o_addr, o_cmd} = {1'b1, a, a[5:0]};
    o_mode = m;
    @(negedge i_core_clk);
    // released lines flip so a late sample cannot match
    {o_req, o_addr, o_cmd} = {1'b0, ~a, ~a[5:0]};
    n = 0;
    while (!(i_done || i_abort) && n < 8) begin
      @(negedge i_core_clk);
      n++;
    end
    ok = i_done;
  endtask
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmt_pkg::*;
  logic        i_core_clk = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
  logic        i_err_clear = 1'b0, i_dma_req, o_reg_rvalid, o_dma_done, o_dma_abort;
  logic        o_err_invalid_frame, eflag = 1'b0;
  logic [19:0] i_reg_addr = 20'h00000;
  logic [31:0] i_reg_wdata = 32'h00000000, o_reg_rdata, i_vme_addr, o_err_vme_addr, eaddr;
  logic [5:0]  i_vme_cmd, o_err_vme_cmd;
  logic [39:0] o_sys_addr;
  pmt_mode_t   i_mode;
  logic [19:0] adr[5] = '{20'h00200, 20'h401FC, 20'h001FC, 20'h40200, 20'h00202};
  int unsigned mem[int];
  int          fails = 0, checks = 0, seed = 32'hFD7A;
  always #4 i_core_clk = ~i_core_clk;
  pmt_top pmt_top_inst (.*);
  pmt_dma_master pmt_dma_master_inst (.i_core_clk(i_core_clk), .i_done(o_dma_done),
    .i_abort(o_dma_abort), .o_req(i_dma_req), .o_mode(i_mode), .o_addr(i_vme_addr),
    .o_cmd(i_vme_cmd));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d);
    logic hit;
    int   i;
    hit = a >= 20'h00200 && a <= 20'h401FC && a[1:0] == 2'h0;
    i = (a - 20'h00200) >> 2;
    @(negedge i_core_clk);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {w, !w, a, d};
    if (w && hit) mem[i] = d;
    @(negedge i_core_clk);
    {i_reg_wr, i_reg_rd} = 2'h0;
    if (!w) begin
      @(negedge i_core_clk);
      chk(o_reg_rvalid, 1);
      chk(o_reg_rdata, hit && mem.exists(i) ? mem[i] : 0);
    end
  endtask
  task automatic xf(input pmt_mode_t m, input logic v);
    logic [31:0] a, p;
    logic [39:0] e;
    logic        ok;
    int          o;
    a = $random(seed);
    p = ($random(seed) & 32'h7FFFFFFF) | {v, 31'h0};
    o = m < 2 ? 9 : m == PMT_MODE_40_4K ? 12 : 13;
    acc(1, 20'(32'h200 + ((a >> o) & 32'hFFFF) * 4), p);
    pmt_dma_master_inst.xfer(m, a, $random(seed) & 3, ok);
    e = ({10'h0, p[29:0]} << o) | (a & ((32'h1 << o) - 1));
    e = e & (m == PMT_MODE_34_512 ? 40'h3FFFFFFFF : 40'h7FFFFFFFFF);
    chk(ok, v);
    chk(o_dma_abort, !v);
    if (v) chk(o_sys_addr, e);
    else begin
      if (!eflag) {eflag, eaddr} = {1'b1, a};
      chk(o_err_invalid_frame, 1);
      chk({o_err_vme_cmd, o_err_vme_addr}, {eaddr[5:0], eaddr});
    end
  endtask
  initial begin
    repeat (3) @(negedge i_core_clk);
    i_srst = 1'b0;
    acc(0, 20'h10000, 0);
    foreach (adr[k]) begin
      acc(1, adr[k], $random(seed));
      acc(0, adr[k], 0);
    end
    $display("test registers done");
    for (int k = 0; k < 8; k++) xf(pmt_mode_t'(k % 4), 1);
    $display("test translation done");
    xf(PMT_MODE_40_4K, 0);
    xf(PMT_MODE_34_512, 0);
    @(negedge i_core_clk);
    i_err_clear = 1'b1;
    @(negedge i_core_clk);
    {i_err_clear, eflag} = 2'h0;
    chk(o_err_invalid_frame, 0);
    xf(PMT_MODE_40_8K, 0);
    $display("test error capture done");
    end_of_test();
  end
  // about twenty times the expected run
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
